// >>> core/dsip_top.sv
// sample input port: pin capture, coding, fifo and power sequencing
// What this block does
// - Each rising edge of the external sample clock captures the parallel sample word.
// - The word is twelve bits with bit 11 the most significant and bit 0 the least.
// - Words may be straight binary or two's complement, chosen by the mode input.
// - An open or grounded mode input means mode 0, so mode is 0 until a level is seen.
// - One new word is taken per sample clock at up to 50 MSPS (two system cycles high and two low), half the documented 100 MSPS.
// - A high sleep level powers down in 5 us and a low level powers up in 3 ms; open means awake.
// - The true current code is all ones at full scale, so it carries the converted word.
// - The complement current code mirrors it while powered, is zero while powered down, and is full scale when the word is all zeros.
`timescale 1ns/10ps
`default_nettype none

module dsip_fifo #(
	parameter int W     = 12,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic         sys_clk_i,
	input  wire logic         nrst_i,
	// fill side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// drain side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_reg [DEPTH];
	logic [AW:0]  wr_ptr_reg;
	logic [AW:0]  rd_ptr_reg;
	logic         push;
	logic         pop;

	// full when pointers differ only in the wrap bit
	assign in_ready_o  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
	assign out_valid_o = (wr_ptr_reg != rd_ptr_reg);
	assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// storage
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
		end
	end

	// pointers
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end
endmodule : dsip_fifo

module dsip_top
	import dsip_pkg::*;
#(
	parameter int   PUP_CYCLES = PUP_CYC,  // power-up wait, shorten in simulation
	parameter int   PDN_CYCLES = PDN_CYC,  // power-down wait
	parameter logic MODE_TWOS  = 1'b1      // mode level that selects two's complement
) (
	// clock and reset
	input  wire logic                sys_clk_i,
	input  wire logic                nrst_i,
	// sample pins
	input  wire logic                smp_clk_i,
	input  wire logic [SAMPLE_W-1:0] smp_data_i,
	// strap and power pins
	input  wire logic                mode_i,
	input  wire logic                sleep_i,
	// converter codes
	output logic [SAMPLE_W-1:0]      true_current_out_o,
	output logic [SAMPLE_W-1:0]      complement_current_out_o,
	// status
	output logic                     powered_o,
	output logic                     overrun_o
);
	localparam int SW = SAMPLE_W + 3;      // data, clock, mode, sleep
	localparam int CW = $clog2(((PUP_CYCLES > PDN_CYCLES) ? PUP_CYCLES : PDN_CYCLES) + 1);  // fits either wait

	logic [SW-1:0]       ff1_reg, ff2_reg, ff3_reg, lvl_reg;
	logic [SW-1:0]       lvl_next;
	logic                clk_d_reg;
	logic                smp_rise;
	logic [SAMPLE_W-1:0] data_lvl;
	logic                mode_lvl, sleep_lvl, clk_lvl;
	logic [SAMPLE_W-1:0] cap_word_reg;
	logic                cap_vld_reg;
	logic                fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [SAMPLE_W-1:0] fifo_out_data;
	dsip_pwr_e           pwr_reg;
	logic [CW-1:0]       cnt_reg;

	// converts a pin word to straight binary
	function automatic logic [SAMPLE_W-1:0] to_binary(input logic [SAMPLE_W-1:0] w, input logic m);
		to_binary          = w;
		to_binary[MSB_POS] = w[MSB_POS] ^ (m == MODE_TWOS);
	endfunction : to_binary

	// three-stage pin synchroniser, first stage read only by the second
	always_ff @(posedge sys_clk_i) begin
		ff1_reg <= {sleep_i, mode_i, smp_clk_i, smp_data_i};
		ff2_reg <= ff1_reg;
		ff3_reg <= ff2_reg;
	end

	// a bit changes once stages two and three agree
	assign lvl_next = (ff2_reg & ~(ff2_reg ^ ff3_reg)) | (lvl_reg & (ff2_reg ^ ff3_reg));
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			lvl_reg   <= {SLEEP_RST, MODE_RST, 1'b0, WORD_ZERO};
			clk_d_reg <= 1'b0;
		end else begin
			lvl_reg   <= lvl_next;
			clk_d_reg <= lvl_reg[SAMPLE_W];
		end
	end

	assign data_lvl  = lvl_reg[SAMPLE_W-1:0];  // bit 11 msb, bit 0 lsb
	assign clk_lvl   = lvl_reg[SAMPLE_W];
	assign mode_lvl  = lvl_reg[SAMPLE_W+1];
	assign sleep_lvl = lvl_reg[SAMPLE_W+2];
	assign smp_rise  = clk_lvl && !clk_d_reg;

	// capture one word per rising sample edge
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			cap_word_reg <= WORD_ZERO;
			cap_vld_reg  <= 1'b0;
		end else begin
			cap_vld_reg <= smp_rise;
			if (smp_rise) begin
				cap_word_reg <= to_binary(data_lvl, mode_lvl);
			end
		end
	end

	// overrun when the fifo is full at capture time
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			overrun_o <= 1'b0;
		end else begin
			overrun_o <= cap_vld_reg && !fifo_in_ready;
		end
	end

	dsip_fifo #(
		.W     (SAMPLE_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i   (sys_clk_i),
		.nrst_i      (nrst_i),
		.in_valid_i  (cap_vld_reg),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   (cap_word_reg),
		.out_valid_o (fifo_out_valid),
		.out_ready_i (powered_o),
		.out_data_o  (fifo_out_data)
	);
	assign fifo_pop = fifo_out_valid && powered_o;

	// power sequencing with fixed waits
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			pwr_reg <= DSIP_ACTIVE;
			cnt_reg <= '0;
		end else begin
			case (pwr_reg)
				DSIP_ACTIVE: begin
					if (sleep_lvl) begin
						pwr_reg <= DSIP_POWERING_DOWN;
						cnt_reg <= CW'(PDN_CYCLES - 1);
					end
				end
				DSIP_POWERING_DOWN: begin
					if (cnt_reg == '0) begin
						pwr_reg <= DSIP_ASLEEP;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				DSIP_ASLEEP: begin
					if (!sleep_lvl) begin
						pwr_reg <= DSIP_POWERING_UP;
						cnt_reg <= CW'(PUP_CYCLES - 1);
					end
				end
				DSIP_POWERING_UP: begin
					if (cnt_reg == '0) begin
						pwr_reg <= DSIP_ACTIVE;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				default: begin
					pwr_reg <= DSIP_ACTIVE;
				end
			endcase
		end
	end

	// powered flag, low from the start of power-down to the end of power-up
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			powered_o <= 1'b1;
		end else begin
			powered_o <= (pwr_reg == DSIP_ACTIVE) && !sleep_lvl;
		end
	end

	// current codes, both idle while powered down
	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			true_current_out_o       <= WORD_ZERO;
			complement_current_out_o <= ~WORD_ZERO;  // zero word mirrored
		end else if (!powered_o) begin
			true_current_out_o       <= WORD_ZERO;
			complement_current_out_o <= WORD_ZERO;
		end else if (fifo_pop) begin
			true_current_out_o       <= fifo_out_data;
			complement_current_out_o <= ~fifo_out_data;
		end else begin
			complement_current_out_o <= ~true_current_out_o;  // mirror restored after wake
		end
	end

	// checks
	property p_capture;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		smp_rise |=> cap_vld_reg && (cap_word_reg == to_binary($past(data_lvl), $past(mode_lvl)));
	endproperty
	a_capture: assert property (p_capture) else $error("sample edge did not capture word");

	property p_bit_order;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		smp_rise |=> cap_word_reg[MSB_POS-1:0] == $past(smp_data_i[MSB_POS-1:0], 4);
	endproperty
	a_bit_order: assert property (p_bit_order) else $error("low data bits reordered");

	property p_straight;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		smp_rise && (mode_lvl != MODE_TWOS) |=> cap_word_reg == $past(data_lvl);
	endproperty
	a_straight: assert property (p_straight) else $error("straight binary word altered");

	property p_mode_default;
		@(posedge sys_clk_i)
		!$past(nrst_i) |-> !mode_lvl;
	endproperty
	a_mode_default: assert property (p_mode_default) else $error("mode not 0 after reset");

	property p_one_per_edge;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		cap_vld_reg |=> !cap_vld_reg;
	endproperty
	a_one_per_edge: assert property (p_one_per_edge) else $error("two captures back to back");

	property p_power_down;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		(pwr_reg == DSIP_ACTIVE) && sleep_lvl |=> (pwr_reg == DSIP_POWERING_DOWN) && !powered_o
			&& (cnt_reg == CW'(PDN_CYCLES - 1));
	endproperty
	a_power_down: assert property (p_power_down) else $error("sleep did not start power-down");

	property p_true_out;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		fifo_pop |=> true_current_out_o == $past(fifo_out_data);
	endproperty
	a_true_out: assert property (p_true_out) else $error("true code missed fifo word");

	property p_mirror;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		$past(powered_o) && powered_o |-> complement_current_out_o == ~true_current_out_o;
	endproperty
	a_mirror: assert property (p_mirror) else $error("complement code does not mirror");

	property p_twos_msb;
		@(posedge sys_clk_i) disable iff (!nrst_i)
		smp_rise && (mode_lvl == MODE_TWOS) |=> cap_word_reg[MSB_POS] != $past(data_lvl[MSB_POS]);
	endproperty
	a_twos_msb: assert property (p_twos_msb) else $error("msb not inverted in twos mode");
endmodule : dsip_top

`default_nettype wire

// >>> core/dsip_pkg.sv
// constants shared by the sample input port
package dsip_pkg;
	localparam int SAMPLE_W      = 12;        // sample word width
	localparam int MSB_POS       = 11;        // most significant data bit
	localparam int FIFO_DEPTH    = 8;         // words held between capture and output
	localparam int CLK_PERIOD_PS = 5000;      // 200 MHz system clock
	localparam int SYNC_STAGES   = 3;         // pin synchroniser length
	localparam int PDN_TIME_NS   = 5000;      // power-down time, 5 us
	localparam int PUP_TIME_NS   = 3000000;   // power-up time, 3 ms
	localparam int MAX_RATE_MSPS = 100;       // fastest documented update rate
	// least times round up to whole cycles
	localparam int PDN_CYC = (PDN_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int PUP_CYC = (PUP_TIME_NS / 1000) * ((1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic MODE_RST  = 1'b0;        // mode level assumed when strap is open
	localparam logic SLEEP_RST = 1'b0;        // sleep level assumed when pin is open
	localparam logic [SAMPLE_W-1:0] WORD_ZERO = 12'h000;
	// power sequencing states
	typedef enum logic [1:0] {
		DSIP_ACTIVE,
		DSIP_POWERING_DOWN,
		DSIP_ASLEEP,
		DSIP_POWERING_UP
	} dsip_pwr_e;
endpackage : dsip_pkg

// >>> verification/dsip_src.sv
// sample source model driving the parallel sample pins
`timescale 1ns/10ps
`default_nettype none

module dsip_src
	import dsip_pkg::*;
(
	// clock
	input  wire logic           sys_clk_i,
	// sample pins
	output logic                smp_clk_o,
	output logic [SAMPLE_W-1:0] smp_data_o
);
	// pins start idle, clock low
	initial begin
		smp_clk_o  = 1'b0;
		smp_data_o = 12'h000;
	end

	// one word per 14 system cycles, well below the top rate
	task automatic send(input logic [SAMPLE_W-1:0] word);
		@(posedge sys_clk_i); // pins change only at a rising edge
		smp_data_o <= word; // bit 11 drives the msb pin
		repeat (4) @(posedge sys_clk_i);
		smp_clk_o <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		smp_clk_o <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		smp_data_o <= ~word; // hold over, stale value no longer shown
		@(posedge sys_clk_i);
	endtask : send
endmodule : dsip_src

`default_nettype wire

// >>> verification/dac_sample_input_port_tb.sv
// testbench for the sample input port
`timescale 1ns/10ps
`default_nettype none

module dac_sample_input_port_tb;
	import dsip_pkg::*;
	logic                sys_clk_i;
	logic                nrst_i;
	logic                smp_clk;
	logic                mode_i;
	logic                sleep_i;
	logic [SAMPLE_W-1:0] smp_data;
	logic [SAMPLE_W-1:0] true_o;
	logic [SAMPLE_W-1:0] comp_o;
	logic                powered_o;
	logic                overrun_o;
	int                  ovr_cnt = 0;
	int                  n_fail;
	int                  tests_run;

	// 200 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	// design with shortened power waits
	dsip_top #(.PUP_CYCLES(20), .PDN_CYCLES(10), .MODE_TWOS(1'b1)) uut (
		.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .smp_clk_i(smp_clk), .smp_data_i(smp_data),
		.mode_i(mode_i), .sleep_i(sleep_i), .true_current_out_o(true_o),
		.complement_current_out_o(comp_o), .powered_o(powered_o), .overrun_o(overrun_o)
	);

	// far side sample source
	dsip_src src (.sys_clk_i(sys_clk_i), .smp_clk_o(smp_clk), .smp_data_o(smp_data));

	// count dropped-word pulses
	always @(posedge sys_clk_i) begin
		if (overrun_o === 1'b1) begin
			ovr_cnt <= ovr_cnt + 1;
		end
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [SAMPLE_W-1:0] got, input logic [SAMPLE_W-1:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// bounded wait for a power level and true code
	task automatic wait_state(input logic pwr, input logic [SAMPLE_W-1:0] code);
		int i;
		for (i = 0; i < 200; i++) begin
			@(negedge sys_clk_i); // outputs settled mid-cycle
			if (powered_o === pwr && true_o === code) begin
				return;
			end
		end
		n_fail++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, true_o, code);
		wrap_up();
	endtask : wait_state

	task automatic t_reset();
		@(posedge sys_clk_i);
		@(negedge sys_clk_i);
		chk(true_o, 12'h000);
		chk(comp_o, 12'hFFF);
		chk({11'h000, powered_o}, 12'h001);
		chk({11'h000, overrun_o}, 12'h000);
		$display("test reset done");
	endtask : t_reset

	// mode 0 straight binary, full scale both ways
	task automatic t_binary();
		logic [SAMPLE_W-1:0] tbl [3] = '{12'hFFF, 12'h000, 12'hA53};
		foreach (tbl[k]) begin
			src.send(tbl[k]);
			wait_state(1'b1, tbl[k]);
			chk(true_o, tbl[k]);
			chk(comp_o, ~tbl[k]);
		end
		$display("test binary done");
	endtask : t_binary

	// mode 1 two's complement, msb turned round
	task automatic t_twos();
		logic [SAMPLE_W-1:0] tbl [3] = '{12'h800, 12'h7FF, 12'h123};
		@(posedge sys_clk_i);
		mode_i <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
		foreach (tbl[k]) begin
			src.send(tbl[k]);
			wait_state(1'b1, tbl[k] ^ 12'h800);
			chk(true_o, tbl[k] ^ 12'h800);
		end
		@(posedge sys_clk_i);
		mode_i <= 1'b0;
		repeat (6) @(posedge sys_clk_i);
		$display("test twos done");
	endtask : t_twos

	// sleep, queue past full, wake and drain
	task automatic t_sleep();
		int k;
		sleep_i <= 1'b1;
		wait_state(1'b0, 12'h000);
		chk(comp_o, 12'h000);
		for (k = 1; k <= 8; k++) begin
			src.send(12'h100 + 12'(k));
		end
		chk(12'(ovr_cnt), 12'h000);
		src.send(12'h109);
		repeat (3) @(posedge sys_clk_i);
		chk(12'(ovr_cnt), 12'h001);
		sleep_i <= 1'b0;
		wait_state(1'b1, 12'h108); // wait out power-up
		chk(comp_o, ~12'h108);
		$display("test sleep done");
	endtask : t_sleep

	// main sequence
	initial begin
		nrst_i = 1'b0;
		mode_i = 1'b0;
		sleep_i = 1'b0;
		n_fail = 0;
		tests_run = 0;
		repeat (3) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		t_reset();
		t_binary();
		t_twos();
		t_sleep();
		wrap_up();
	end
endmodule : dac_sample_input_port_tb

`default_nettype wire
